// ===== testbench/dbu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbu_host_model (
  // clock
  input wire logic sys_clk,
  // command bytes toward the debug unit
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic rx_ready,
  // replies from the debug unit
  input wire dbu_pkg::dbu_rsp_s rsp,
  output logic rsp_ready
);
  import dbu_pkg::*;

  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rsp_ready = 1'b0;
  end

  // ----------------------------------------
  // host side byte traffic
  // ----------------------------------------
  // byte stays offered until the edge that takes it; valid is left up
  task automatic send(input logic [7:0] b);
    logic tk;
    int n;
    rx_valid = 1'b1;
    rx_byte = b;
    n = 0;
    do
    begin
      tk = rx_ready;
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (tk !== 1'b1 && n < 2000);
  endtask

  // released line shows the inverse of the last byte, not a stale copy
  task automatic idle();
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask

  // first character after reset or a break relearns the bit rate
  task automatic autobaud();
    @(posedge sys_clk);
    #1;
    send(8'h80);
    idle();
  endtask

  // slow gives extra stall cycles before the host is ready
  task automatic recv(output logic [7:0] d, input int slow);
    int n;
    repeat (slow + 1) @(posedge sys_clk);
    #1;
    rsp_ready = 1'b1;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 2000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    d = rsp.data;
    @(posedge sys_clk);
    #1;
    rsp_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_onchip_debug_break_counter.sv
`timescale 1ns/1ps
`default_nettype none
module test_onchip_debug_break_counter;
  import dbu_pkg::*;
  logic sys_clk, rst, rx_valid, rx_ready, rsp_ready, debug_pin_i, debug_pin_o, debug_pin_oe_n;
  logic autobaud_set, clk_switch, autobaud_clr, cpu_decode, cpu_fetch, cpu_stall, cpu_brk_loop;
  logic xfer_load, xfer_dec, read_protect_option, debug_mode_flag;
  logic [7:0] rx_byte, cpu_opcode, b0;
  logic [15:0] cpu_pc, xfer_cnt, debug_counter_rd, v;
  dbu_rsp_s rsp;
  dbu_op_s op, last_op;
  int miscompares, samples_checked, op_cnt, clr_cnt, n;
  logic [7:0] blk[6] = '{8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d};

  // open-drain pin with pull-up; the host leaves it released
  assign debug_pin_i = debug_pin_oe_n ? 1'b1 : debug_pin_o;

  dbu_debug_unit dbu_debug_unit_i (.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_ready(rx_ready), .rsp(rsp), .rsp_ready(rsp_ready),
    .debug_pin_i(debug_pin_i), .debug_pin_o(debug_pin_o), .debug_pin_oe_n(debug_pin_oe_n),
    .autobaud_set(autobaud_set), .clk_switch(clk_switch), .autobaud_clr(autobaud_clr),
    .cpu_decode(cpu_decode), .cpu_opcode(cpu_opcode), .cpu_fetch(cpu_fetch), .cpu_pc(cpu_pc),
    .cpu_stall(cpu_stall), .cpu_brk_loop(cpu_brk_loop), .op(op), .xfer_load(xfer_load),
    .xfer_cnt(xfer_cnt), .xfer_dec(xfer_dec), .read_protect_option(read_protect_option),
    .debug_mode_flag(debug_mode_flag), .debug_counter_rd(debug_counter_rd));

  dbu_host_model dbu_host_model_i (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .rsp(rsp), .rsp_ready(rsp_ready));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    if (op.valid === 1'b1)
    begin
      op_cnt++;
      last_op = op;
    end
    if (autobaud_clr === 1'b1)
      clr_cnt++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic chk1(input string s, input logic e, input logic g);
    chk(s, {15'h0, e}, {15'h0, g});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    tick(1);
    foreach (q[i]) dbu_host_model_i.send(q[i]);
    dbu_host_model_i.idle();
  endtask
  task automatic rd2(input logic [7:0] c, output logic [15:0] d);
    cmd('{c});
    dbu_host_model_i.recv(d[15:8], 0);
    dbu_host_model_i.recv(d[7:0], 2);
  endtask
  task automatic rd1(input logic [7:0] c, output logic [7:0] d);
    cmd('{c});
    dbu_host_model_i.recv(d, 1);
  endtask
  task automatic breakpoint_opcode(input logic [7:0] opc);
    cpu_opcode = opc;
    cpu_decode = 1'b1;
    tick(1);
    cpu_decode = 1'b0;
  endtask
  task automatic fetch(input logic [15:0] pc);
    cpu_pc = pc;
    cpu_fetch = 1'b1;
    tick(1);
    cpu_fetch = 1'b0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge sys_clk);
    $display("[ERR] watchdog expected finish seen hang");
    miscompares++;
    stop_test();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    {rst, autobaud_set, clk_switch, cpu_decode, cpu_fetch, xfer_load, xfer_dec} = 7'h40;
    {cpu_opcode, cpu_pc, xfer_cnt, read_protect_option} = '0;
    {miscompares, samples_checked, op_cnt, clr_cnt} = '0;
    tick(16);
    rst = 1'b0;
    chk("cnt reset", 16'hffff, debug_counter_rd);
    chk1("pin reset", 1'b1, debug_pin_oe_n);
    chk1("ready reset", 1'b1, rx_ready);
    dbu_host_model_i.autobaud();
    rd2(CMD_REV, v);
    chk("rev", REV_ID, v);
    rd2(CMD_CNT_RD, v);
    chk("cnt normal", 16'hffff, v);
    rd1(CMD_STAT, b0);
    chk("stat normal", 16'h0001, {8'h00, b0});
    cmd('{CMD_CTL_WR, 8'h80});
    tick(4);
    chk1("enter dbg", 1'b1, cpu_stall);
    rd1(CMD_CTL_RD, b0);
    chk("ctl", 16'h0080, {8'h00, b0});
    $display("test normal mode done");
    cmd('{CMD_CNT_WR, 8'h12, 8'h34});
    tick(4);
    chk("cnt inv", 16'hedcb, debug_counter_rd);
    rd2(CMD_CNT_RD, v);
    chk("cnt read", 16'hedcb, v);
    xfer_cnt = 16'h0003;
    xfer_load = 1'b1;
    tick(1);
    xfer_load = 1'b0;
    xfer_dec = 1'b1;
    tick(1);
    xfer_dec = 1'b0;
    tick(2);
    chk("xfer cnt", 16'hfffd, debug_counter_rd);
    $display("test counter access done");
    read_protect_option = 1'b1;
    n = op_cnt;
    foreach (blk[i])
      cmd('{blk[i]});
    tick(6);
    chk("rp blocked", 16'(n), 16'(op_cnt));
    cmd('{CMD_CRC});
    tick(6);
    chk("crc op", 16'(n + 1), 16'(op_cnt));
    chk("crc code", {8'h00, CMD_CRC}, {8'h00, last_op.code});
    cmd('{CMD_REG_RD, 8'h00, 8'h10});
    tick(6);
    chk1("ram blk", 1'b1, last_op.ram_blk);
    cmd('{CMD_REG_WR, 8'h0f, 8'h05});
    tick(6);
    chk1("periph", 1'b0, last_op.ram_blk);
    chk("reg addr", 16'h0f05, {4'h0, last_op.addr});
    rd1(CMD_STAT, b0);
    chk("stat rp", 16'h00a1, {8'h00, b0});
    n = op_cnt;
    cmd('{8'h0f});
    cmd('{8'h2a});
    tick(6);
    chk("unassigned", 16'(n), 16'(op_cnt));
    chk1("no reply", 1'b0, rsp.valid);
    read_protect_option = 1'b0;
    $display("test protect done");
    cmd('{CMD_CTL_WR, 8'h08});
    tick(12);
    v = debug_counter_rd;
    chk1("cyc cleared", 1'b1, v > 16'h0000 && v < 16'h0020);
    tick(3);
    chk("cyc up", v + 16'h0003, debug_counter_rd);
    cmd('{CMD_CTL_WR, 8'h88});
    tick(4);
    v = debug_counter_rd;
    tick(5);
    chk("cyc frozen", v, debug_counter_rd);
    cmd('{CMD_CTL_WR, 8'h90});
    cmd('{CMD_CNT_WR, 8'h00, 8'h05});
    cmd('{CMD_CTL_WR, 8'h10});
    tick(3);
    chk1("cd run", 1'b0, debug_mode_flag);
    n = 0;
    while (debug_mode_flag !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk1("cd time", 1'b1, n >= 1 && n <= 10);
    chk("cd zero", 16'hffff, debug_counter_rd);
    cmd('{CMD_CTL_WR, 8'h98});
    cmd('{CMD_CNT_WR, 8'h01, 8'h00});
    cmd('{CMD_CTL_WR, 8'h18});
    tick(4);
    fetch(16'h00ff);
    tick(1);
    chk1("pc miss", 1'b0, cpu_stall);
    chk("pc hold", 16'hfeff, debug_counter_rd);
    fetch(16'h0100);
    chk1("pc hit", 1'b1, cpu_stall);
    $display("test counter modes done");
    cmd('{CMD_CTL_WR, 8'h00});
    tick(4);
    breakpoint_opcode(8'h00);
    tick(2);
    chk1("brk off", 1'b0, cpu_stall);
    cmd('{CMD_CTL_WR, 8'h40});
    tick(4);
    breakpoint_opcode(8'h3c);
    chk1("not brk", 1'b0, cpu_stall);
    tick(1);
    breakpoint_opcode(BREAKPOINT_OPCODE);
    chk1("brk on", 1'b1, cpu_stall);
    chk1("brk flag", 1'b1, debug_mode_flag);
    cmd('{CMD_CTL_WR, 8'h60});
    tick(4);
    breakpoint_opcode(BREAKPOINT_OPCODE);
    chk1("loop", 1'b1, cpu_brk_loop);
    chk1("loop run", 1'b0, cpu_stall);
    rd1(CMD_STAT, b0);
    chk("idle bit", 16'h0041, {8'h00, b0});
    n = op_cnt;
    cmd('{CMD_PC_RD});
    tick(6);
    chk("loop gated", 16'(n), 16'(op_cnt));
    cmd('{CMD_CTL_WR, 8'h40});
    tick(4);
    chk1("loop off", 1'b0, cpu_brk_loop);
    breakpoint_opcode(BREAKPOINT_OPCODE);
    chk1("loop entry", 1'b1, cpu_stall);
    chk1("loop flag", 1'b1, debug_mode_flag);
    $display("test breakpoints done");
    autobaud_set = 1'b1;
    clk_switch = 1'b1;
    tick(1);
    clk_switch = 1'b0;
    chk1("break oe", 1'b0, debug_pin_oe_n);
    chk1("break drive", 1'b0, debug_pin_o);
    n = 0;
    while (debug_pin_oe_n !== 1'b1 && n < 5000)
    begin
      tick(1);
      n++;
    end
    chk("break len", 16'd4096, 16'(n));
    chk("ab clear", 16'd1, 16'(clr_cnt));
    autobaud_set = 1'b0;
    dbu_host_model_i.autobaud();
    $display("test break done");
    n = 0;
    tick(1);
    while (rx_ready === 1'b1 && n < 20)
    begin
      dbu_host_model_i.send(CMD_REV);
      n++;
    end
    dbu_host_model_i.idle();
    chk1("fifo full", 1'b0, rx_ready);
    for (int i = 0; i < 2 * n; i++)
    begin
      dbu_host_model_i.recv(b0, i % 3);
      chk("drain", 16'h0001, {8'h00, b0});
    end
    tick(4);
    chk1("fifo empty", 1'b1, rx_ready);
    chk1("drained", 1'b0, rsp.valid);
    $display("test fifo done");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verilog/dbu_debug_unit.sv
// What this block does
// R01: clock switch with autobaud set drives a 4096-clock break and clears autobaud.
// R02: host sends a new autobaud character after a clock change.
// R03: breakpoint opcode 00h with breakpoints enabled stalls CPU and enters debug mode.
// R04: breakpoints disabled: breakpoint signal ignored, opcode acts as no-operation.
// R05: loop mode keeps CPU looping on breakpoint, still serving DMA and interrupts.
// R06: status idle bit reads true while CPU loops on a breakpoint.
// R07: host stops looping CPU by clearing the break-loop flag.
// R08: after loop flag clears, next breakpoint sets debug mode flag itself.
// R09: most commands stay disabled while looping; usable only in debug mode.
// R10: cycle mode counts from debug exit until re-entry or FFFFh.
// R11: cycle mode clears counter to 0000h on each debug exit.
// R12: countdown mode keeps value, decrements, breaks at zero, freezes on entry.
// R13: PC-match mode never resets or decrements; breaks before matching instruction.
// R14: counter doubles as transfer byte counter and keeps CRC residue.
// R15: host loads counter last before leaving debug mode.
// R16: counter reads return the bitwise inverse of stored value in debug mode; command 03h outside debug returns FFFFh.
// R17: cycle counting decrements from maximum so inverted read counts up.
// R18: outside debug only commands 00h, 02h, 03h, 04h, 05h operate.
// R19: read protect disables 06h, 07h and 0Ah to 0Dh.
// R20: read protect lets 08h/09h reach peripherals, blocks on-chip RAM.
// R21: counter write 01h, counter read 03h, CRC 0Eh unaffected by read protect.
// R22: host sends 80h first after reset or break.
// R23: characters are start bit, eight data bits LSB first, stop bit.
// R24: unassigned command bytes are ignored with no action or data.
`timescale 1ns/1ps
`default_nettype none
module dbu_debug_unit (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // received command bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output logic rx_ready,
  // reply bytes to transmitter
  output dbu_pkg::dbu_rsp_s rsp,
  input wire logic rsp_ready,
  // debug pin, open drain
  input wire logic debug_pin_i,
  output logic debug_pin_o,
  output logic debug_pin_oe_n,
  // autobaud and clock switch
  input wire logic autobaud_set,
  input wire logic clk_switch,
  output logic autobaud_clr,
  // cpu
  input wire logic cpu_decode,
  input wire logic [7:0] cpu_opcode,
  input wire logic cpu_fetch,
  input wire logic [15:0] cpu_pc,
  output logic cpu_stall,
  output logic cpu_brk_loop,
  // transfer engine
  output dbu_pkg::dbu_op_s op,
  input wire logic xfer_load,
  input wire logic [15:0] xfer_cnt,
  input wire logic xfer_dec,
  // options and state
  input wire logic read_protect_option,
  output logic debug_mode_flag,
  output logic [15:0] debug_counter_rd
);
  import dbu_pkg::*;

  typedef enum {ST_CMD, ST_ARG_HI, ST_ARG_LO, ST_SEND_LO} dbu_state_e;

  // ----------------------------------------
  // state
  // ----------------------------------------
  dbu_state_e st_r, st_nxt;
  logic [7:0] ctl_r, ctl_nxt, cmd_r, cmd_nxt, hi_r, hi_nxt, lo_r, lo_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic loop_r, loop_nxt;
  dbu_rsp_s rsp_r, rsp_nxt;
  dbu_op_s op_r, op_nxt;
  logic [12:0] brk_cnt_r;
  logic brk_act_r, brk_oe_n_r, clr_r, stall_r, loopo_r;
  logic [15:0] rd_r;
  logic [2:0] pin_sync_r;
  logic pin_lvl_r;
  logic f_valid;
  logic [7:0] f_byte;

  // ----------------------------------------
  // command FIFO
  // ----------------------------------------
  wire can_go = !rsp_r.valid || rsp_ready;
  wire f_pop = f_valid && can_go && (st_r != ST_SEND_LO);

  dbu_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_data(rx_byte), // one deframed character per byte; see R23
    .in_ready(rx_ready),
    .out_valid(f_valid),
    .out_data(f_byte),
    .out_ready(f_pop)
  );

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire dbg = ctl_r[CTL_DBG];
  wire brk_en = ctl_r[CTL_BRK_EN];
  wire loop_en = ctl_r[CTL_LOOP];
  wire [1:0] mode = ctl_r[CTL_MODE_HI:CTL_MODE_LO];
  wire rp = read_protect_option;
  wire brk_seen = cpu_decode && (cpu_opcode == BREAKPOINT_OPCODE);
  wire brk_take = brk_seen && brk_en && !dbg; // see R03 see R04
  wire loop_hit = brk_take && loop_en; // see R05
  wire stop_hit = brk_take && !loop_en; // see R08
  wire down_hit = (mode == MODE_DOWN) && !dbg && (cnt_r == CNT_ONE); // see R12
  wire pc_hit = (mode == MODE_PCM) && !dbg && cpu_fetch && (cpu_pc == cnt_r); // see R13
  wire enter = stop_hit || down_hit || pc_hit;
  wire ctl_wr = f_pop && (st_r == ST_ARG_LO) && (cmd_r == CMD_CTL_WR);
  wire exit_dbg = dbg && !ctl_nxt[CTL_DBG];
  // the mode written together with the exit decides the clear
  wire [1:0] mode_nxt = ctl_nxt[CTL_MODE_HI:CTL_MODE_LO];
  wire exit_cyc = exit_dbg && (mode_nxt == MODE_CYC);
  wire [11:0] reg_addr = {hi_r[3:0], f_byte};
  wire ram_addr = reg_addr < PERIPH_BASE;
  wire [7:0] stat = 8'((32'(dbg) << STAT_DBG) | (32'(loop_r) << STAT_IDLE)
                       | (32'(rp) << STAT_RP) | (32'(pin_lvl_r) << STAT_PIN)); // see R06
  wire [15:0] cnt_view = dbg ? ~cnt_r : ALL_ONES; // see R16
  wire is_rp_cmd = (f_byte == CMD_PC_WR) || (f_byte == CMD_PC_RD)
                   || ((f_byte >= CMD_PM_WR) && (f_byte <= CMD_DM_RD));
  wire is_reg_cmd = (f_byte == CMD_REG_WR) || (f_byte == CMD_REG_RD);
  wire grant_direct = dbg && ((is_rp_cmd && !rp) || (f_byte == CMD_CRC)); // see R19 see R21

  // ----------------------------------------
  // control register and loop state
  // ----------------------------------------
  always_comb
  begin
    ctl_nxt = ctl_r;
    if (ctl_wr)
      ctl_nxt = f_byte; // see R07
    if (enter)
      ctl_nxt[CTL_DBG] = 1'b1; // see R03 see R08
    loop_nxt = loop_r;
    if (loop_hit)
      loop_nxt = 1'b1;
    else if (!ctl_nxt[CTL_LOOP] || ctl_nxt[CTL_DBG])
      loop_nxt = 1'b0;
  end

  // ----------------------------------------
  // debug counter
  // ----------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (xfer_load)
      cnt_nxt = xfer_cnt; // see R14
    else if (f_pop && (st_r == ST_ARG_LO) && (cmd_r == CMD_CNT_WR) && dbg)
      cnt_nxt = {hi_r, f_byte}; // see R21
    else if (xfer_dec && dbg)
      cnt_nxt = cnt_r - CNT_ONE; // see R14
    else if (exit_cyc)
      cnt_nxt = CNT_MAX; // see R11 see R17
    else if (!dbg && (mode == MODE_CYC || mode == MODE_DOWN) && cnt_r != CNT_ZERO)
      cnt_nxt = cnt_r - CNT_ONE; // see R10 see R12
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    rsp_nxt = rsp_r;
    op_nxt = '0;
    if (rsp_r.valid && rsp_ready)
      rsp_nxt.valid = 1'b0;
    case (st_r)
      ST_CMD:
        if (f_pop)
        begin
          cmd_nxt = f_byte;
          case (f_byte)
            CMD_REV:
            begin
              rsp_nxt = '{1'b1, REV_ID[15:8]};
              lo_nxt = REV_ID[7:0];
              st_nxt = ST_SEND_LO;
            end
            CMD_STAT: rsp_nxt = '{1'b1, stat};
            CMD_CTL_RD: rsp_nxt = '{1'b1, ctl_r};
            CMD_CTL_WR: st_nxt = ST_ARG_LO; // see R18
            CMD_CNT_WR: st_nxt = ST_ARG_HI;
            CMD_CNT_RD:
            begin
              rsp_nxt = '{1'b1, cnt_view[15:8]};
              lo_nxt = cnt_view[7:0];
              st_nxt = ST_SEND_LO;
            end
            default:
              if (is_reg_cmd && dbg)
                st_nxt = ST_ARG_HI; // see R09
              else if (grant_direct)
                op_nxt = '{1'b1, f_byte, 12'h000, 1'b0};
              // other bytes dropped: see R18 see R24
          endcase
        end
      ST_ARG_HI:
        if (f_pop)
        begin
          hi_nxt = f_byte;
          st_nxt = ST_ARG_LO;
        end
      ST_ARG_LO:
        if (f_pop)
        begin
          if (cmd_r == CMD_REG_WR || cmd_r == CMD_REG_RD)
            op_nxt = '{1'b1, cmd_r, reg_addr, rp && ram_addr}; // see R20
          st_nxt = ST_CMD;
        end
      ST_SEND_LO:
        if (can_go)
        begin
          rsp_nxt = '{1'b1, lo_r};
          st_nxt = ST_CMD;
        end
      default: st_nxt = ST_CMD;
    endcase
  end

  // ----------------------------------------
  // clock-switch break
  // ----------------------------------------
  wire brk_start = clk_switch && autobaud_set && !brk_act_r; // see R01
  wire brk_done = brk_act_r && (brk_cnt_r == BREAK_ZERO);
  wire brk_act_nxt = brk_start || (brk_act_r && !brk_done);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      brk_act_r <= 1'b0;
      brk_oe_n_r <= 1'b1;
      brk_cnt_r <= BREAK_ZERO;
      clr_r <= 1'b0;
    end
    else
    begin
      brk_act_r <= brk_act_nxt; // see R01
      brk_oe_n_r <= !brk_act_nxt;
      brk_cnt_r <= brk_start ? BREAK_LAST : brk_cnt_r - 13'(brk_act_r && !brk_done);
      clr_r <= brk_start;
    end
  end

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_sync_r <= 3'h7;
      pin_lvl_r <= 1'b1;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], debug_pin_i};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_lvl_r <= pin_sync_r[2];
    end
  end

  // ----------------------------------------
  // main registers
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= ST_CMD;
      ctl_r <= CTL_RST;
      cmd_r <= CMD_REV;
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      cnt_r <= CNT_ZERO;
      loop_r <= 1'b0;
      rsp_r <= '0;
      op_r <= '0;
      stall_r <= 1'b0;
      loopo_r <= 1'b0;
      rd_r <= ALL_ONES;
    end
    else
    begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      cmd_r <= cmd_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      cnt_r <= cnt_nxt;
      loop_r <= loop_nxt;
      rsp_r <= rsp_nxt;
      op_r <= op_nxt;
      stall_r <= ctl_nxt[CTL_DBG]; // see R03
      loopo_r <= loop_nxt; // see R05
      rd_r <= ~cnt_nxt; // see R16
    end
  end

  assign rsp = rsp_r;
  assign op = op_r;
  assign debug_pin_o = 1'b0;
  assign debug_pin_oe_n = brk_oe_n_r;
  assign autobaud_clr = clr_r;
  assign cpu_stall = stall_r;
  assign cpu_brk_loop = loopo_r;
  assign debug_mode_flag = ctl_r[CTL_DBG];
  assign debug_counter_rd = rd_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [12:0] low_len_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      low_len_r <= BREAK_ZERO;
    else
      low_len_r <= debug_pin_oe_n ? BREAK_ZERO : low_len_r + 13'h0001;
  end

  chk_break_len: assert property ($rose(debug_pin_oe_n) |-> $past(low_len_r) == BREAK_LAST) // see R01
    else $error("break length wrong");
  chk_break_clr: assert property ($fell(debug_pin_oe_n) |-> autobaud_clr) // see R01
    else $error("autobaud not cleared with break");
  chk_brk_enter: assert property (brk_take && !loop_en && !ctl_wr |=> cpu_stall && debug_mode_flag) // see R03
    else $error("breakpoint did not stall");
  chk_brk_nop: assert property (brk_seen && !brk_en && !dbg && mode == MODE_OFF && !ctl_wr
                                |=> !debug_mode_flag) // see R04
    else $error("disabled breakpoint acted");
  chk_loop_idle: assert property (loop_hit && !ctl_wr |=> cpu_brk_loop && stat[STAT_IDLE]
                                  && !cpu_stall) // see R06
    else $error("loop idle not shown");
  chk_cyc_clear: assert property (exit_cyc && !xfer_load
                                  |=> debug_counter_rd == CNT_ZERO ##1 cnt_r == CNT_MAX - 1) // see R11
    else $error("cycle count not cleared");
  chk_pc_match: assert property (pc_hit |=> cpu_stall ##0 $stable(cnt_r)) // see R13
    else $error("pc match did not break");
  chk_rp_gate: assert property (op.valid |-> $past(dbg) && !($past(rp) && (op.code == CMD_PC_WR
                                || op.code == CMD_PC_RD))) // see R19
    else $error("blocked command granted");
  chk_normal_rsp: assert property (st_r == ST_CMD && f_pop && !dbg && f_byte == CMD_CNT_RD
                                   |=> rsp.valid && rsp.data == 8'hff) // see R18
    else $error("counter read outside debug not all ones");
endmodule
`default_nettype wire

// ===== verilog/dbu_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dbu_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r, cnt_r, cnt_nxt;
  logic ready_r, ovalid_r;
  logic [W-1:0] odata_r;

  // output stage plus DEPTH-1 words of storage hold DEPTH words
  wire wr = in_valid && ready_r;
  wire pop = ovalid_r && out_ready;
  wire stage_free = !ovalid_r || pop;
  wire mem_rd = stage_free && (cnt_r != '0);
  wire byp = stage_free && (cnt_r == '0) && wr;
  wire mem_wr = wr && !byp;
  assign cnt_nxt = cnt_r + AW'(mem_wr) - AW'(mem_rd);
  assign in_ready = ready_r;
  assign out_valid = ovalid_r;
  assign out_data = odata_r;

  always_ff @(posedge sys_clk)
  begin
    if (mem_wr)
      mem[wp_r] <= in_data;
    if (mem_rd)
      odata_r <= mem[rp_r];
    else if (byp)
      odata_r <= in_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ovalid_r <= 1'b0;
      ready_r <= 1'b1;
    end
    else
    begin
      wp_r <= wp_r + AW'(mem_wr);
      rp_r <= rp_r + AW'(mem_rd);
      cnt_r <= cnt_nxt;
      ovalid_r <= mem_rd || byp || (ovalid_r && !pop);
      ready_r <= cnt_nxt != AW'(DEPTH - 1);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/dbu_pkg.sv
package dbu_pkg;

  // ----------------------------------------
  // command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_REV = 8'h00;
  localparam logic [7:0] CMD_CNT_WR = 8'h01;
  localparam logic [7:0] CMD_STAT = 8'h02;
  localparam logic [7:0] CMD_CNT_RD = 8'h03;
  localparam logic [7:0] CMD_CTL_WR = 8'h04;
  localparam logic [7:0] CMD_CTL_RD = 8'h05;
  localparam logic [7:0] CMD_PC_WR = 8'h06;
  localparam logic [7:0] CMD_PC_RD = 8'h07;
  localparam logic [7:0] CMD_REG_WR = 8'h08;
  localparam logic [7:0] CMD_REG_RD = 8'h09;
  localparam logic [7:0] CMD_PM_WR = 8'h0a;
  localparam logic [7:0] CMD_DM_RD = 8'h0d;
  localparam logic [7:0] CMD_CRC = 8'h0e;
  localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;

  // ----------------------------------------
  // debug_control_reg and debug_status_reg layout
  // ----------------------------------------
  localparam int CTL_DBG = 7;
  localparam int CTL_BRK_EN = 6;
  localparam int CTL_LOOP = 5;
  localparam int CTL_MODE_HI = 4;
  localparam int CTL_MODE_LO = 3;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam int STAT_DBG = 7;
  localparam int STAT_IDLE = 6;
  localparam int STAT_RP = 5;
  localparam int STAT_PIN = 0;

  // counter modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_CYC = 2'h1;
  localparam logic [1:0] MODE_DOWN = 2'h2;
  localparam logic [1:0] MODE_PCM = 2'h3;

  // ----------------------------------------
  // values and timing
  // ----------------------------------------
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  // revision value is arbitrary
  localparam logic [15:0] REV_ID = 16'h0101;
  localparam logic [11:0] PERIPH_BASE = 12'hf00;
  localparam int BREAK_CLKS = 4096;
  localparam logic [12:0] BREAK_LAST = 13'(BREAK_CLKS - 1);
  localparam logic [12:0] BREAK_ZERO = 13'h0000;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dbu_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [11:0] addr;
    logic ram_blk;
  } dbu_op_s;

endpackage
